// ===== spi_eeprom_core.sv
// Serial EEPROM slave: link shifter, instruction decode, protection and write sequencer
`timescale 1ns/1ps
//
// Overview of operation
// R1 - Sample serial input on rising clock edge
// R2 - Shift serial output on falling clock edge
// R3 - Output tri-stated while chip select high
// R4 - Host frames sessions with chip select edges
// R5 - Host toggles hold only while clock low
// R6 - First byte is opcode; unknown ones ignored
// R7 - Decode set, clear write enable, read status
// R8 - Decode write status, read array, write array
// R9 - Busy flag high throughout internal write
// R10 - Enable latch set and cleared by instructions
// R11 - Block protect codes select protected ranges
// R12 - Status layout: enable, zeros, protect, latch, busy
// R13 - Pin plus enable refuse status writes
// R14 - Protected blocks never written; others need latch
// R15 - Power-up clears write enable latch
// R16 - Latch sets only on select rise after command
// R17 - Write uses only low thirteen address bits
// R18 - Programming starts at ending select rise
// R19 - Busy ignores all but status read
// R20 - Host waits after power-up before access; bench accesses three core cycles after reset release
// R21 - Page load wraps within sixty-four bytes
// R22 - Finished write cycle clears enable latch
// R23 - Status write changes bits two, three, seven
// R24 - Reads stream, address increments and wraps
// R25 - Hold freezes shifter and tri-states output
module spi_eeprom_core import spi_eeprom_pkg::*; #(
    parameter int write_cycles = write_cycle_cycles // Shorten for simulation
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic hold_n_in,
    input wire logic wp_n_in,
    output logic so_out,
    output logic so_oe_n_out
);
    // Storage
    logic [7:0] mem [mem_bytes]; // Nonvolatile array
    logic [7:0] pg_data [page_bytes]; // Page load buffer, link side
    // Link side state
    logic frame_rst; // Chip select high clears the per-frame shifter
    logic [2:0] bit_cnt_reg; // Bits taken in current byte
    logic [1:0] byte_cnt_reg; // Byte index, saturates on data
    logic [6:0] rx_reg; // Partial received byte
    logic tx_valid_reg; // Output has something to send
    logic [7:0] tx_reg; // Byte being shifted out
    logic so_reg; // Output bit, falling edge flop
    logic so_en_reg; // Output drive flag, falling edge flop
    logic [12:0] rd_addr_reg; // Next read address
    logic [page_bytes-1:0] pg_mask_reg; // Loaded page slots
    logic [7:0] st_s1_reg; // Status sync, first stage
    logic [7:0] st_s2_reg; // Status sync, second stage
    frame_t frame_reg; // Summary of the current frame
    // Core side state
    logic cs_s1_reg, cs_s2_reg, cs_s3_reg; // Chip select sync and edge
    logic wp_s1_reg, wp_s2_reg; // Protect pin sync
    logic wel_reg; // Write enable latch
    logic bp_low_reg, bp_high_reg, pin_en_reg; // Nonvolatile status bits
    prog_state_t state_reg; // Write sequencer
    logic [page_w-1:0] idx_reg; // Copy index within page
    logic [20:0] timer_reg; // Write cycle timer
    // Derived
    logic hold_ok; // Not paused
    logic byte_done; // Last bit of a byte arrives this edge
    logic [7:0] rx_byte; // Byte completed this edge
    cmd_kind_t kind_now; // Kind valid at this edge
    logic busy_s; // Busy as seen on the link side
    logic [7:0] status_word; // Status as presented
    logic cs_rise; // Frame ended, one core cycle
    logic busy_reg; // Internal write in progress
    logic hw_lock; // Pin and enable lock the status
    logic write_status_cmd_go, write_go; // Accepted write commits
    logic [12:0] copy_addr; // Array address under copy
    logic mem_we; // Array write strobe
    logic prog_done; // Write cycle ends this cycle

    // Array protection by block protect code
    function automatic logic in_protected(input logic [1:0] bp, input logic [12:0] a);
        case (bp)
            2'h0: in_protected = 1'b0;
            2'h1: in_protected = a >= quarter_base;
            2'h2: in_protected = a >= half_base;
            default: in_protected = 1'b1;
        endcase
    endfunction // R11

    // Opcode decode; while busy only status read survives
    function automatic cmd_kind_t decode(input logic [7:0] op, input logic busy);
        cmd_kind_t k;
        case (op)
            set_write_enable_cmd: k = cmd_set_write_enable_cmd; // R7
            clear_write_enable_cmd: k = cmd_clear_write_enable_cmd; // R7
            read_status_cmd: k = cmd_read_status_cmd; // R7
            write_status_cmd: k = cmd_write_status_cmd; // R8
            read_array_cmd: k = cmd_read; // R8
            write_array_cmd: k = cmd_write; // R8
            default: k = cmd_none; // R6
        endcase
        if (busy && k != cmd_read_status_cmd) begin
            k = cmd_none; // R19
        end
        decode = k;
    endfunction

    assign frame_rst = rst_in | cs_n_in;
    assign hold_ok = hold_n_in; // R25
    assign byte_done = bit_cnt_reg == last_bit;
    assign rx_byte = {rx_reg, si_in}; // R1
    assign busy_s = st_s2_reg[busy_bit];
    assign kind_now = (byte_cnt_reg == opcode_byte) ? decode(rx_byte, busy_s) : frame_reg.kind;

    // Bit and byte counters, receive shift, drive flag; cleared each frame
    always_ff @(posedge sck_in or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 2'h0;
            rx_reg <= 7'h00;
            tx_valid_reg <= 1'b0;
        end else if (hold_ok) begin // R25
            bit_cnt_reg <= bit_cnt_reg + 3'h1; // R6
            rx_reg <= rx_byte[6:0]; // R1
            if (byte_done) begin
                if (byte_cnt_reg != data_byte) begin
                    byte_cnt_reg <= byte_cnt_reg + 2'h1;
                end
                if (kind_now == cmd_read_status_cmd ||
                    (kind_now == cmd_read && byte_cnt_reg == addr_lo_byte)) begin
                    tx_valid_reg <= 1'b1; // R24
                end
            end
        end
    end

    // Frame summary, address capture and page slots; one driver, stable once select rises
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            frame_reg.kind <= cmd_none;
            frame_reg.ok <= 1'b0;
            frame_reg.status_data <= 8'h00;
            frame_reg.wr_addr <= 13'h0000;
            pg_mask_reg <= '0;
        end else if (hold_ok) begin
            if (byte_done) begin
                frame_reg.kind <= kind_now; // R6
                case (kind_now)
                    cmd_set_write_enable_cmd, cmd_clear_write_enable_cmd: frame_reg.ok <= byte_cnt_reg == opcode_byte; // R16
                    cmd_write_status_cmd: frame_reg.ok <= byte_cnt_reg == addr_hi_byte;
                    cmd_write: frame_reg.ok <= byte_cnt_reg == data_byte; // R17
                    default: frame_reg.ok <= 1'b0;
                endcase
                if (byte_cnt_reg == addr_hi_byte) begin
                    frame_reg.status_data <= rx_byte;
                    frame_reg.wr_addr[12:8] <= rx_byte[4:0]; // R17
                end else if (byte_cnt_reg == addr_lo_byte) begin
                    frame_reg.wr_addr[7:0] <= rx_byte;
                end else if (byte_cnt_reg == data_byte && frame_reg.kind == cmd_write) begin
                    pg_mask_reg[frame_reg.wr_addr[page_w-1:0]] <= 1'b1;
                    frame_reg.wr_addr[page_w-1:0] <= frame_reg.wr_addr[page_w-1:0] + 6'h01; // R21
                end
                // Only an accepted write opcode empties the page, so a copy in flight is safe
                if (byte_cnt_reg == opcode_byte && kind_now == cmd_write) begin
                    pg_mask_reg <= '0;
                end
            end else begin
                frame_reg.ok <= 1'b0; // Partial byte breaks the sequence
            end
        end
    end

    // Page buffer contents, no reset needed behind the slot mask
    always_ff @(posedge sck_in) begin
        if (hold_ok && byte_done && byte_cnt_reg == data_byte && frame_reg.kind == cmd_write) begin
            pg_data[frame_reg.wr_addr[page_w-1:0]] <= rx_byte;
        end
    end

    // Outgoing byte: status repeats, array reads stream and wrap
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            tx_reg <= 8'h00;
            rd_addr_reg <= 13'h0000;
        end else if (hold_ok && byte_done) begin
            if (kind_now == cmd_read_status_cmd) begin
                tx_reg <= st_s2_reg; // R19
            end else if (kind_now == cmd_read && byte_cnt_reg == addr_lo_byte) begin
                tx_reg <= mem[{frame_reg.wr_addr[12:8], rx_byte}];
                rd_addr_reg <= {frame_reg.wr_addr[12:8], rx_byte} + 13'h0001;
            end else if (kind_now == cmd_read && byte_cnt_reg == data_byte) begin
                tx_reg <= mem[rd_addr_reg];
                rd_addr_reg <= rd_addr_reg + 13'h0001; // R24
            end
        end
    end

    // Output bit changes on the falling edge; the sck count is a few
    // edges behind status, which the two-stage sync tolerates
    always_ff @(negedge sck_in or posedge frame_rst) begin
        if (frame_rst) begin
            so_reg <= 1'b0;
            so_en_reg <= 1'b0;
        end else if (hold_ok) begin // R25
            so_reg <= tx_reg[~bit_cnt_reg]; // R2
            so_en_reg <= tx_valid_reg;
        end
    end

    assign so_out = so_reg;
    assign so_oe_n_out = cs_n_in | ~hold_n_in | ~so_en_reg; // R3 R25

    // Status into the link domain; only moves on link edges
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            st_s1_reg <= 8'h00;
            st_s2_reg <= 8'h00;
        end else begin
            st_s1_reg <= status_word;
            st_s2_reg <= st_s1_reg;
        end
    end

    // Status layout
    always_comb begin
        status_word = 8'h00; // R12
        status_word[protect_pin_enable] = pin_en_reg;
        status_word[block_protect_high] = bp_high_reg;
        status_word[block_protect_low] = bp_low_reg;
        status_word[wel_bit] = wel_reg;
        status_word[busy_bit] = busy_reg; // R9
    end

    // Pin synchronisers in the core domain
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            wp_s1_reg <= 1'b1;
            wp_s2_reg <= 1'b1;
        end else begin
            cs_s1_reg <= cs_n_in;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            wp_s1_reg <= wp_n_in;
            wp_s2_reg <= wp_s1_reg;
        end
    end

    // Frame summary is quiet once select is high: no link edges arrive then
    assign cs_rise = cs_s2_reg & ~cs_s3_reg; // R18
    assign busy_reg = state_reg != prog_idle; // R9
    assign hw_lock = pin_en_reg & ~wp_s2_reg; // R13
    assign write_status_cmd_go = cs_rise && !busy_reg && frame_reg.kind == cmd_write_status_cmd && frame_reg.ok &&
                     wel_reg && !hw_lock; // R13
    assign write_go = cs_rise && !busy_reg && frame_reg.kind == cmd_write && frame_reg.ok &&
                      wel_reg; // R14
    assign copy_addr = {frame_reg.wr_addr[12:page_w], idx_reg};
    assign mem_we = state_reg == prog_copy && pg_mask_reg[idx_reg] &&
                    !in_protected({bp_high_reg, bp_low_reg}, copy_addr); // R14
    assign prog_done = state_reg == prog_wait && timer_reg == 21'(write_cycles - 1);

    // Write enable latch; power-up leaves it clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wel_reg <= 1'b0; // R15
        end else if (cs_rise && !busy_reg && frame_reg.ok && frame_reg.kind == cmd_set_write_enable_cmd) begin
            wel_reg <= 1'b1; // R10 R16
        end else if (cs_rise && !busy_reg && frame_reg.ok && frame_reg.kind == cmd_clear_write_enable_cmd) begin
            wel_reg <= 1'b0; // R10
        end else if (prog_done) begin
            wel_reg <= 1'b0; // R22
        end
    end

    // Nonvolatile protect bits; written data lands only on bits 2, 3, 7
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            {pin_en_reg, bp_high_reg, bp_low_reg} <= nv_reset;
        end else if (write_status_cmd_go) begin
            pin_en_reg <= frame_reg.status_data[protect_pin_enable]; // R23
            bp_high_reg <= frame_reg.status_data[block_protect_high]; // R11
            bp_low_reg <= frame_reg.status_data[block_protect_low];
        end
    end

    // Write sequencer: copy page for array writes, then time the cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= prog_idle;
            idx_reg <= '0;
            timer_reg <= 21'h000000;
        end else begin
            case (state_reg)
                prog_idle: begin
                    idx_reg <= '0;
                    timer_reg <= 21'h000000;
                    if (write_go) begin
                        state_reg <= prog_copy; // R18
                    end else if (write_status_cmd_go) begin
                        state_reg <= prog_wait;
                    end
                end
                prog_copy: begin
                    idx_reg <= idx_reg + 6'h01;
                    if (idx_reg == 6'(page_bytes - 1)) begin
                        state_reg <= prog_wait;
                    end
                end
                default: begin
                    timer_reg <= timer_reg + 21'h000001;
                    if (prog_done) begin
                        state_reg <= prog_idle;
                    end
                end
            endcase
        end
    end

    // Array programming
    always_ff @(posedge clk_in) begin
        if (mem_we) begin
            mem[copy_addr] <= pg_data[idx_reg];
        end
    end

    // Checks
    chk_wel_done_clear: assert property (@(posedge clk_in) disable iff (rst_in) // R22
        $fell(busy_reg) |-> !wel_reg) else $error("latch left set after write cycle");
    chk_busy_from_commit: assert property (@(posedge clk_in) disable iff (rst_in) // R18
        $rose(busy_reg) |-> $past(cs_rise)) else $error("write began without select rise");
    chk_busy_holds: assert property (@(posedge clk_in) disable iff (rst_in) // R9
        $rose(busy_reg) |-> busy_reg [*8]) else $error("busy dropped early");
    chk_set_write_enable_cmd_sets: assert property (@(posedge clk_in) disable iff (rst_in) // R16
        cs_rise && !busy_reg && frame_reg.ok && frame_reg.kind == cmd_set_write_enable_cmd |=> wel_reg)
        else $error("enable not latched");
    chk_clear_write_enable_cmd_clears: assert property (@(posedge clk_in) disable iff (rst_in) // R10
        cs_rise && !busy_reg && frame_reg.ok && frame_reg.kind == cmd_clear_write_enable_cmd |=> !wel_reg)
        else $error("enable not cleared");
    chk_status_locked: assert property (@(posedge clk_in) disable iff (rst_in) // R13
        cs_rise && hw_lock |=> $stable({pin_en_reg, bp_high_reg, bp_low_reg}))
        else $error("locked status changed");
    chk_busy_ignores: assert property (@(posedge clk_in) disable iff (rst_in) // R19
        cs_rise && busy_reg && !prog_done |=> $stable({pin_en_reg, bp_high_reg, bp_low_reg}) &&
        busy_reg)
        else $error("command accepted while busy");
    chk_no_latch_write: assert property (@(posedge clk_in) disable iff (rst_in) // R14
        $rose(busy_reg) && state_reg == prog_copy |-> $past(wel_reg))
        else $error("array write without latch");
    chk_protect_skip: assert property (@(posedge clk_in) disable iff (rst_in) // R14
        mem_we |-> !(bp_high_reg && bp_low_reg)) else $error("full protect written");
    chk_hold_freeze: assert property (@(posedge sck_in) disable iff (rst_in || cs_n_in) // R25
        !hold_n_in |=> $stable(bit_cnt_reg)) else $error("shifter moved in hold");
    cov_set_write_enable_cmd_commit: cover property (@(posedge clk_in) disable iff (rst_in)
        cs_rise && frame_reg.kind == cmd_set_write_enable_cmd && frame_reg.ok);
    cov_array_write: cover property (@(posedge clk_in) disable iff (rst_in) write_go);
    cov_status_write: cover property (@(posedge clk_in) disable iff (rst_in) write_status_cmd_go);
    cov_read_busy: cover property (@(posedge clk_in) disable iff (rst_in)
        busy_reg && !so_oe_n_out);
endmodule // spi_eeprom_core

// ===== spi_eeprom_pkg.sv
// Shared constants and types for the serial EEPROM command and protect front end
package spi_eeprom_pkg;
    // Instruction opcodes
    localparam logic [7:0] set_write_enable_cmd = 8'h06;
    localparam logic [7:0] clear_write_enable_cmd = 8'h04;
    localparam logic [7:0] read_status_cmd = 8'h05;
    localparam logic [7:0] write_status_cmd = 8'h01;
    localparam logic [7:0] read_array_cmd = 8'h03;
    localparam logic [7:0] write_array_cmd = 8'h02;
    // Array geometry
    localparam int addr_w = 13;
    localparam int page_w = 6;
    localparam int page_bytes = 64;
    localparam int mem_bytes = 8192;
    // Block protect region starts
    localparam logic [12:0] quarter_base = 13'h1800;
    localparam logic [12:0] half_base = 13'h1000;
    // Status bit positions and reset value of the nonvolatile bits
    localparam int busy_bit = 0;
    localparam int wel_bit = 1;
    localparam int block_protect_low = 2;
    localparam int block_protect_high = 3;
    localparam int protect_pin_enable = 7;
    localparam logic [2:0] nv_reset = 3'h0;
    // Byte positions inside a frame
    localparam logic [1:0] opcode_byte = 2'h0;
    localparam logic [1:0] addr_hi_byte = 2'h1;
    localparam logic [1:0] addr_lo_byte = 2'h2;
    localparam logic [1:0] data_byte = 2'h3;
    localparam logic [2:0] last_bit = 3'h7;
    // Timing
    localparam int clk_period_ns = 4;
    localparam int write_cycle_ms = 5;
    localparam int write_cycle_cycles = write_cycle_ms * 1000000 / clk_period_ns;
    localparam int powerup_to_read_delay_ms = 1;
    localparam int powerup_to_write_delay_ms = 1;
    // Decoded instruction kinds
    typedef enum logic [2:0] {
        cmd_none, cmd_set_write_enable_cmd, cmd_clear_write_enable_cmd, cmd_read_status_cmd, cmd_write_status_cmd, cmd_read, cmd_write
    } cmd_kind_t;
    // Frame summary handed from the link side to the core at chip select rise
    typedef struct packed {
        cmd_kind_t kind;
        logic ok;
        logic [7:0] status_data;
        logic [12:0] wr_addr;
    } frame_t;
    // Internal write sequencer
    typedef enum logic [1:0] {prog_idle, prog_copy, prog_wait} prog_state_t;
endpackage

// ===== spi_host_model.sv
// Behavioural serial host that frames transfers to the EEPROM link
`timescale 1ns/1ps
module spi_host_model (
    output logic sck_out,
    output logic cs_n_out,
    output logic si_out,
    output logic hold_n_out,
    input wire logic so_in,
    input wire logic so_oe_n_in
);
    logic [7:0] tx[$]; // Bytes to send
    logic [7:0] rx[$]; // Bytes captured
    logic mode3 = 1'b1; // Clock idles high when set
    int hold_at = -1; // Bit index that pauses, none if negative
    logic oe_seen; // Output driven at any sample
    logic hold_oe; // Stays high if released all through the pause
    initial begin
        sck_out = 1'b1;
        cs_n_out = 1'b1;
        si_out = 1'b0;
        hold_n_out = 1'b1;
    end
    // Pause with the clock low; clock keeps toggling with junk data
    task automatic pause(input logic b);
        #8 hold_n_out = 1'b0;
        repeat (2) begin
            #16 sck_out = 1'b1;
            si_out = ~si_out;
            hold_oe &= so_oe_n_in;
            #16 sck_out = 1'b0;
        end
        si_out = b;
        #8 hold_n_out = 1'b1;
    endtask
    // One framed transfer, MSB first; the clock stands still outside it
    task automatic frame();
        logic [7:0] b;
        int k;
        k = 0;
        rx = {};
        oe_seen = 1'b0;
        hold_oe = 1'b1;
        #13.3 cs_n_out = 1'b0;
        #20;
        foreach (tx[i]) begin
            for (int j = 7; j >= 0; j--) begin
                sck_out = 1'b0;
                si_out = tx[i][j];
                if (k == hold_at) pause(tx[i][j]);
                #32 sck_out = 1'b1;
                b = {b[6:0], so_oe_n_in ? ~so_in : so_in}; // Released line reads inverted
                oe_seen |= !so_oe_n_in;
                k++;
                #32;
            end
            rx.push_back(b);
        end
        sck_out = mode3;
        #20 cs_n_out = 1'b1;
        si_out = ~si_out; // Released line must not show a stale bit
        #40;
    endtask
endmodule // spi_host_model

// ===== spi_eeprom_command_protect_logic_tb_top.sv
// Self-checking bench for the serial EEPROM command and protect front end
`timescale 1ns/1ps
module spi_eeprom_command_protect_logic_tb_top import spi_eeprom_pkg::*;;
    logic clk_in, rst_in, wp_n_in, sck, cs_n, si, hold_n, so, so_oe_n;
    int failures, num_checks;
    logic [1:0] bp; // Block protect code held by the device
    logic [7:0] shadow [logic [12:0]]; // Expected array contents
    logic [7:0] op;
    spi_eeprom_core #(.write_cycles(400)) DUT (.clk_in(clk_in), .rst_in(rst_in),
        .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n_in),
        .so_out(so), .so_oe_n_out(so_oe_n));
    spi_host_model host (.sck_out(sck), .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n),
        .so_in(so), .so_oe_n_in(so_oe_n));
    // Core clock
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic prot(input logic [12:0] a);
        return bp == 2'h3 || (bp == 2'h2 && a >= half_base) || (bp == 2'h1 && a >= quarter_base);
    endfunction
    task automatic cmd(input logic [7:0] c);
        host.tx = {c};
        host.frame();
    endtask
    task automatic st(output logic [7:0] s);
        host.tx = {read_status_cmd, 8'h00};
        host.frame();
        s = host.rx[1];
    endtask
    task automatic cst(input logic [7:0] exp, input logic [7:0] m);
        logic [7:0] s;
        st(s);
        chk8(s & m, exp);
    endtask
    // Poll busy with a bound; a stuck flag counts as a mismatch
    task automatic wait_idle();
        logic [7:0] s;
        for (int i = 0; i < 30; i++) begin
            st(s);
            if (s[busy_bit] === 1'b0) return;
        end
        failures++;
    endtask
    task automatic ws(input logic [7:0] d, input logic en);
        if (en) cmd(set_write_enable_cmd);
        host.tx = {write_status_cmd, d};
        host.frame();
        wait_idle();
    endtask
    // Array write of n random bytes; shadow follows page wrap and protection
    task automatic wr(input logic [15:0] a, input int n, input logic en);
        logic [12:0] p;
        logic [7:0] d;
        if (en) cmd(set_write_enable_cmd);
        host.tx = {write_array_cmd, a[15:8], a[7:0]};
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            p = {a[12:6], 6'(a[5:0] + i)};
            if (en && !prot(p)) shadow[p] = d;
            host.tx.push_back(d);
        end
        host.frame();
        wait_idle();
    endtask
    task automatic rd(input logic [12:0] a, input int n);
        host.tx = {read_array_cmd, 8'(a >> 8), a[7:0]};
        for (int i = 0; i < n; i++) host.tx.push_back(8'h00);
        host.frame();
        for (int i = 0; i < n; i++) chk8(host.rx[3 + i], shadow[13'(a + i)]);
    endtask
    task automatic test_done();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog sized well beyond the expected run
    initial begin
        #400000;
        failures++;
        test_done();
    end
    initial begin
        failures = 0;
        num_checks = 0;
        bp = 2'h0;
        wp_n_in = 1'b1;
        rst_in = 1'b1;
        void'($urandom(32'h5286));
        repeat (6) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        cst(8'h00, 8'hff);
        host.mode3 = 1'b0;
        cst(8'h00, 8'hff);
        // Stray opcodes keep the output released
        for (int i = 0; i < 6; i++) begin
            do op = 8'($urandom); while (op inside {[8'h01:8'h06]});
            host.tx = {op, 8'h00};
            host.frame();
            chk8(8'(host.oe_seen), 8'h00);
        end
        cmd(set_write_enable_cmd);
        cst(8'h02, 8'hff);
        cmd(clear_write_enable_cmd);
        cst(8'h00, 8'hff);
        ws(8'h8c, 1'b0);
        cst(8'h00, 8'hff);
        wr(16'he13e, 3, 1'b1);
        wr(16'h1fff, 1, 1'b1);
        wr(16'h0000, 1, 1'b1);
        wr(16'h0ffc, 1, 1'b1);
        wr(16'h1800, 1, 1'b1);
        rd(13'h013e, 2);
        rd(13'h0100, 1);
        rd(13'h1fff, 2);
        // Status write then an enable sent while busy
        cmd(set_write_enable_cmd);
        host.tx = {write_status_cmd, 8'hff};
        host.frame();
        cst(8'h01, 8'h01);
        cmd(set_write_enable_cmd);
        wait_idle();
        cst(8'h8c, 8'hff);
        for (int c = 3; c >= 0; c--) begin
            ws({4'h0, 2'(c), 2'h0}, 1'b1);
            bp = 2'(c);
            wr(16'h0ffc, 1, 1'b1);
            wr(16'h1800, 1, 1'b1);
            rd(13'h0ffc, 1);
            rd(13'h1800, 1);
        end
        wr(16'h0ffc, 1, 1'b0);
        rd(13'h0ffc, 1);
        ws(8'h84, 1'b1);
        bp = 2'h1;
        @(negedge clk_in) wp_n_in = 1'b0;
        ws(8'h00, 1'b1);
        cst(8'h84, 8'h8c);
        wr(16'h0ffc, 1, 1'b1);
        rd(13'h0ffc, 1);
        @(negedge clk_in) wp_n_in = 1'b1;
        ws(8'h00, 1'b1);
        cst(8'h00, 8'hff);
        host.hold_at = 3;
        cst(8'h00, 8'hff);
        host.hold_at = 27;
        rd(13'h1fff, 2);
        chk8(8'(host.hold_oe), 8'h01);
        host.hold_at = -1;
        test_done();
    end
endmodule // spi_eeprom_command_protect_logic_tb_top
